// File: verilog/chgseq_top.sv
/*
  Charge sequencer with two-stage safety timer and APB registers.
  Assumes analog comparators arrive asynchronously on pins; the
  timer limits are parameters so a bench can shorten them.
*/
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps

module chgseq_top
  import chgseq_pkg::*;
#(
  parameter int unsigned LONG_LIMIT  = LONG_TICKS,
  parameter int unsigned SHORT_LIMIT = SHORT_TICKS,
  parameter int unsigned TICK_LIMIT  = TICK_CYCLES,
  parameter bit          HAS_BOOST   = 1'b1
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog comparator pins
  input  wire logic        bat_below_short,
  input  wire logic        bat_below_reg,
  input  wire logic        bat_below_recharge,
  input  wire logic        bat_below_lowv,
  input  wire logic        term_current_seen,
  input  wire logic        thermal_shutdown,
  input  wire logic        limit_select_pin,
  // Power stage controls
  output logic             charge_on,
  output logic             boost_on,
  output logic             short_current_on,
  output logic             ramp_on,
  output logic             switching_on,
  output logic             input_limit_high,
  output logic             status_pulse,
  output logic [2:0]       charge_phase
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  wire  [6:0] raw_in = {limit_select_pin, thermal_shutdown, term_current_seen, bat_below_lowv,
                        bat_below_recharge, bat_below_reg, bat_below_short};
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else if (clk_en) begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire s_short  = sync2[0];
  wire s_below  = sync2[1];
  wire s_rch    = sync2[2];
  wire s_lowv   = sync2[3];
  wire s_term   = sync2[4];
  wire s_therm  = sync2[5];
  wire s_selpin = sync2[6];

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [5:0]    ctrl;
  logic [7:0]    param;
  logic [2:0]    fault_code;
  logic          fault_read;
  logic          long_mode;
  chgseq_state_t state;

  wire apb_acc    = psel & penable & clk_en;
  wire apb_wr     = apb_acc & pwrite;
  wire apb_rd     = apb_acc & ~pwrite;
  wire hit_ctrl   = (paddr == ADDR_CTRL);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_param  = (paddr == ADDR_PARAM);
  wire hit_any    = hit_ctrl | hit_status | hit_param;
  wire wr_ctrl    = apb_wr & hit_ctrl;
  wire wr_param   = apb_wr & hit_param;
  wire rd_status  = apb_rd & hit_status;
  wire kick       = wr_ctrl & pwdata[CTRL_KICK];
  wire [5:0] next_ctrl  = {pwdata[CTRL_BOOST], pwdata[CTRL_HIZ], 1'b0,
                           pwdata[CTRL_TERM_EN], 1'b0, pwdata[CTRL_CE]};
  wire [31:0] next_rdata = hit_ctrl   ? {26'h000_0000, ctrl} :
                           hit_status ? {24'h00_0000, long_mode, fault_code, 1'b0, state} :
                           hit_param  ? {24'h00_0000, param} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Tick prescaler
  // ----------------------------------------------------------------
  logic [15:0] presc;
  wire tick_run = ~s_therm;
  wire tick     = tick_run & (presc == 16'(TICK_LIMIT - 1));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) presc <= 16'h0000;
    else if (clk_en & tick_run) presc <= tick ? 16'h0000 : presc + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Safety timers
  // ----------------------------------------------------------------
  logic [23:0] tcount;
  wire charging   = (state == CS_SHORT) | (state == CS_FAST) | (state == CS_REGUL);
  wire long_exp   = long_mode & charging & tick & (tcount == 24'(LONG_LIMIT - 1));
  wire short_exp  = ~long_mode & tick & (tcount == 24'(SHORT_LIMIT - 1));
  wire ce_toggle  = wr_ctrl & (pwdata[CTRL_CE] != ctrl[CTRL_CE]);
  wire rst_cmd    = wr_ctrl & pwdata[CTRL_RESET];
  wire new_cycle  = ce_toggle | rst_cmd |
                    ((state == CS_DONE) & s_rch);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      long_mode <= 1'b1;
      tcount    <= 24'h00_0000;
    end else if (clk_en) begin
      if (short_exp) begin
        long_mode <= 1'b1;
        tcount    <= 24'h00_0000;
      end else if (apb_wr & long_mode) begin
        long_mode <= 1'b0;
        tcount    <= 24'h00_0000;
      end else if (kick | (long_mode & new_cycle)) begin
        tcount    <= 24'h00_0000;
      end else if (tick & (charging | ~long_mode)) begin
        tcount    <= tcount + 24'h00_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl  <= CTRL_RESET_VAL;
      param <= PARAM_RESET_VAL;
    end else if (clk_en) begin
      if (short_exp) begin
        ctrl  <= CTRL_RESET_VAL;
        param <= PARAM_RESET_VAL;
      end else begin
        if (wr_ctrl) ctrl <= next_ctrl;
        if (wr_param) param <= pwdata[7:0];
      end
    end
  end

  // Fault status held until reset; a status read only re-arms the capture
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_code <= FAULT_NONE;
      fault_read <= 1'b1;
    end else if (clk_en) begin
      if (long_exp & fault_read) begin
        fault_code <= FAULT_TIMER;
        fault_read <= 1'b0;
      end else if (rd_status) begin
        fault_read <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Charge sequencer
  // ----------------------------------------------------------------
  chgseq_state_t next_state;
  wire want_boost = HAS_BOOST & ctrl[CTRL_BOOST];
  wire enabled    = ctrl[CTRL_CE] & ~ctrl[CTRL_HIZ];
  wire term_hit   = ctrl[CTRL_TERM_EN] & s_term & ~s_rch;
  always_comb begin
    next_state = state;
    unique case (state)
      CS_FAULT:  next_state = CS_FAULT;
      CS_HIZ:    if (enabled) next_state = want_boost ? CS_BOOST : CS_SHORT;
      CS_BOOST:  if (!enabled || !want_boost) next_state = CS_HIZ;
      CS_SHORT:  if (!s_short) next_state = CS_FAST;
      CS_FAST:   if (s_short) next_state = CS_SHORT;
                 else if (!s_below) next_state = CS_REGUL;
      CS_REGUL:  if (term_hit) next_state = CS_DONE;
                 else if (s_below) next_state = CS_FAST;
      CS_DONE:   next_state = CS_DONE;
      default:   next_state = CS_HIZ;
    endcase
    if (state != CS_FAULT) begin
      if (long_exp) next_state = CS_FAULT;
      else if (!enabled) next_state = CS_HIZ;
      else if (new_cycle & !want_boost) next_state = CS_SHORT;
    end
  end

  // Power-on battery check
  logic [2:0] por_wait;
  wire        por_done = por_wait[2];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state    <= CS_HIZ;
      por_wait <= 3'h0;
    end else if (clk_en) begin
      por_wait <= {por_wait[1:0], 1'b1};
      if (!por_done) state <= (por_wait[1] & s_lowv & enabled) ? CS_SHORT : CS_HIZ;
      else state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Status pulse
  // ----------------------------------------------------------------
  logic [15:0] pcount;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) pcount <= 16'h0000;
    else if (clk_en) begin
      if (long_exp) pcount <= 16'(TICK_LIMIT);
      else if (pcount != 16'h0000) pcount <= pcount - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      charge_on        <= 1'b0;
      boost_on         <= 1'b0;
      short_current_on <= 1'b0;
      ramp_on          <= 1'b0;
      switching_on     <= 1'b0;
      input_limit_high <= 1'b0;
      status_pulse     <= 1'b0;
      charge_phase     <= 3'h0;
    end else if (clk_en) begin
      pready           <= psel & ~penable;
      pslverr          <= psel & ~penable & ~hit_any;
      prdata           <= next_rdata;
      charge_on        <= charging & ~s_therm;
      boost_on         <= (state == CS_BOOST) & ~s_therm;
      short_current_on <= (state == CS_SHORT);
      ramp_on          <= (state == CS_FAST);
      switching_on     <= (charging | (state == CS_BOOST)) & ~s_therm;
      input_limit_high <= long_mode ? s_selpin : param[0];
      status_pulse     <= long_exp | (pcount > 16'h0001);
      charge_phase     <= state;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_HIZ_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state == CS_HIZ |=> !charge_on && !boost_on) else $error("Power stage active in hiz");
  AST_FAULT_STICKS: assert property (@(posedge ref_clk) disable iff (reset)
    state == CS_FAULT |=> state == CS_FAULT) else $error("Fault left without reset");
  AST_FAULT_OFF: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && long_exp |=> state == CS_FAULT ##1 !charge_on) else $error("Charge not stopped");
  AST_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && long_exp |=> status_pulse) else $error("No status pulse");
  AST_WR_SHORT: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && apb_wr && long_mode && !short_exp |=> !long_mode) else $error("Write kept long timer");
  AST_KICK: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && kick && !short_exp |=> tcount == 24'h00_0000 && !ctrl[CTRL_KICK]) else $error("Kick ignored");
  AST_WDOG: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && short_exp |=> long_mode && ctrl == CTRL_RESET_VAL) else $error("Watchdog no restore");
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
    s_therm |=> tcount != $past(tcount) + 24'h00_0001) else $error("Timer ran hot");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    !fault_read && !rd_status |=> $stable(fault_code)) else $error("Fault status changed unread");
  AST_LIMIT: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && long_mode |=> input_limit_high == $past(s_selpin)) else $error("Limit select wrong");
  AST_SHORT_CUR: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state == CS_SHORT |=> short_current_on && !ramp_on) else $error("Short current missing");
  AST_RAMP: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state == CS_FAST |=> ramp_on && !short_current_on) else $error("Ramp missing");
  AST_NO_TERM: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state == CS_REGUL && !ctrl[CTRL_TERM_EN] |=> state != CS_DONE) else $error("Terminated while off");

endmodule // chgseq_top

// File: verilog/chgseq_pkg.sv
/*
  Constants for the charge sequencer and safety timer block.
  Assumes a 25 MHz control clock and an APB register port.
*/
package chgseq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned TICK_US         = 128;
  localparam int unsigned TICK_CYCLES     = (TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LONG_TIMER_MIN  = 15;
  localparam int unsigned SHORT_TIMER_SEC = 32;
  localparam int unsigned LONG_TICKS      = (LONG_TIMER_MIN * 60 * 1_000_000) / TICK_US;
  localparam int unsigned SHORT_TICKS     = (SHORT_TIMER_SEC * 1_000_000) / TICK_US;
  localparam int unsigned PULSE_CYCLES    = TICK_CYCLES;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PARAM  = 8'h08;

  // Control register fields
  localparam int CTRL_CE      = 0;
  localparam int CTRL_RESET   = 1;
  localparam int CTRL_TERM_EN = 2;
  localparam int CTRL_KICK    = 3;
  localparam int CTRL_HIZ     = 4;
  localparam int CTRL_BOOST   = 5;

  localparam logic [5:0] CTRL_RESET_VAL  = 6'h05;
  localparam logic [7:0] PARAM_RESET_VAL = 8'h00;

  // Fault codes
  localparam logic [2:0] FAULT_NONE  = 3'h0;
  localparam logic [2:0] FAULT_TIMER = 3'h6;

  typedef enum logic [2:0] {
    CS_HIZ     = 3'b000,
    CS_SHORT   = 3'b001,
    CS_FAST    = 3'b010,
    CS_REGUL   = 3'b011,
    CS_DONE    = 3'b100,
    CS_BOOST   = 3'b101,
    CS_FAULT   = 3'b110
  } chgseq_state_t;

endpackage

// File: tb/chgseq_host.sv
/*
  Host model: APB master that runs one transfer per call.
  Assumes the slave raises pready in the access phase.
*/
`timescale 1ns/10ps

module chgseq_host (
  // Clock
  input  wire logic        ref_clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // Setup, access until pready, then release with inverted lines
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // chgseq_host

// File: tb/tb_top.sv
/*
  Bench for the charge sequencer: drives comparator pins, reaches
  the registers through the host model. Assumes short timer limits.
*/
`timescale 1ns/10ps

module tb_top;
  import chgseq_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        clk_en  = 1'b1;
  logic        b_short = 1'b1, b_reg = 1'b1, b_rch = 1'b1, b_lowv = 1'b1;
  logic        term = 1'b0, hot = 1'b0, pin = 1'b0, err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        charge_on, boost_on, short_current_on, ramp_on, switching_on;
  logic        input_limit_high, status_pulse;
  logic [2:0]  charge_phase;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          n;

  always #20 ref_clk = ~ref_clk;

  chgseq_top #(.LONG_LIMIT(20), .SHORT_LIMIT(8), .TICK_LIMIT(4), .HAS_BOOST(1'b1)) chgseq_top_i (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bat_below_short(b_short), .bat_below_reg(b_reg),
    .bat_below_recharge(b_rch), .bat_below_lowv(b_lowv), .term_current_seen(term),
    .thermal_shutdown(hot), .limit_select_pin(pin), .charge_on(charge_on), .boost_on(boost_on),
    .short_current_on(short_current_on), .ramp_on(ramp_on), .switching_on(switching_on),
    .input_limit_high(input_limit_high), .status_pulse(status_pulse), .charge_phase(charge_phase));

  chgseq_host chgseq_host_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    chgseq_host_i.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdreg(input logic [7:0] a);
    chgseq_host_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return charge_on;
      1: return boost_on;
      2: return status_pulse;
      3: return ramp_on;
      default: return switching_on;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic val, input int lim);
    n = 0;
    @(negedge ref_clk);
    while (pick(k) !== val && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  function automatic logic exp_lim(input logic long_m, input logic p, input logic p0);
    return long_m ? p : p0;
  endfunction
  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("out_rst", 32'({charge_on, boost_on, status_pulse, switching_on}), 32'h0000_0000);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic end_sim();
    $display("Totals: %0d checks, %0d mismatches", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    v = $urandom(5);
    do_reset();
    wait_on(0, 1'b1, 40);
    chk("short_cur", 32'({short_current_on, ramp_on}), 32'h0000_0002);
    @(posedge ref_clk);
    b_short <= 1'b0;
    wait_on(3, 1'b1, 20);
    chk("ramp", 32'({short_current_on, ramp_on}), 32'h0000_0001);
    chk("phase", 32'(charge_phase), 32'(CS_FAST));
    rdreg(ADDR_CTRL);
    chk("ctrl_rst", 32'(rd[5:0]), 32'(CTRL_RESET_VAL));
    rdreg(8'({6'($urandom_range(3, 63)), 2'b00}));
    chk("unmapped", 32'(err), 32'h0000_0001);
    rdreg(ADDR_STATUS);
    chk("long_mode", 32'(rd[7]), 32'h0000_0001);
    $display("test phases done");
    do_reset();
    repeat (3) begin
      @(posedge ref_clk);
      pin <= 1'($urandom);
      repeat (5) @(negedge ref_clk);
      chk("lim_pin", 32'(input_limit_high), 32'(exp_lim(1'b1, pin, 1'b0)));
    end
    v = $urandom;
    wr(ADDR_PARAM, {24'h0000_00, v[7:0]});
    rdreg(ADDR_STATUS);
    chk("short_mode", 32'(rd[7]), 32'h0000_0000);
    rdreg(ADDR_PARAM);
    chk("param", 32'(rd[7:0]), 32'(v[7:0]));
    chk("lim_bits", 32'(input_limit_high), 32'(exp_lim(1'b0, pin, v[0])));
    repeat (8) begin
      wr(ADDR_CTRL, 32'h0000_000D);
      repeat (8) @(posedge ref_clk);
    end
    rdreg(ADDR_CTRL);
    chk("kick_clr", 32'(rd[3]), 32'h0000_0000);
    rdreg(ADDR_STATUS);
    chk("kick_held", 32'(rd[7]), 32'h0000_0000);
    repeat (60) @(posedge ref_clk);
    rdreg(ADDR_STATUS);
    chk("wd_long", 32'(rd[7]), 32'h0000_0001);
    rdreg(ADDR_PARAM);
    chk("wd_dflt", 32'(rd[7:0]), 32'(PARAM_RESET_VAL));
    $display("test timers done");
    do_reset();
    wr(ADDR_CTRL, 32'h0000_001D);
    repeat (5) @(negedge ref_clk);
    chk("hiz", 32'({charge_on, boost_on}), 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_002D);
    wait_on(1, 1'b1, 20);
    chk("boost", 32'({charge_on, boost_on}), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_003D);
    repeat (5) @(negedge ref_clk);
    chk("hiz_bst", 32'(boost_on), 32'h0000_0000);
    $display("test modes done");
    do_reset();
    b_reg <= 1'b0;
    b_rch <= 1'b0;
    wait_on(0, 1'b1, 40);
    chk("term_chg", 32'(charge_on), 32'h0000_0001);
    @(posedge ref_clk);
    term <= 1'b1;
    wait_on(0, 1'b0, 40);
    chk("term", 32'(charge_on), 32'h0000_0000);
    do_reset();
    wr(ADDR_CTRL, 32'h0000_000B);
    wait_on(0, 1'b1, 20);
    wr(ADDR_CTRL, 32'h0000_0009);
    repeat (10) @(negedge ref_clk);
    chk("no_term", 32'(charge_on), 32'h0000_0001);
    @(posedge ref_clk);
    term <= 1'b0;
    $display("test termination done");
    do_reset();
    wait_on(4, 1'b1, 20);
    chk("therm_pre", 32'(switching_on), 32'h0000_0001);
    @(posedge ref_clk);
    hot <= 1'b1;
    wait_on(4, 1'b0, 10);
    chk("therm_sw", 32'(switching_on), 32'h0000_0000);
    repeat (150) @(posedge ref_clk);
    rdreg(ADDR_STATUS);
    chk("therm_frz", 32'(rd[6:4]), 32'(FAULT_NONE));
    hot <= 1'b0;
    $display("test thermal done");
    do_reset();
    wait_on(0, 1'b1, 40);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(negedge ref_clk);
    v = 32'(charge_phase);
    repeat (120) @(negedge ref_clk);
    chk("frz_phase", 32'(charge_phase), v);
    chk("frz_chg", 32'(charge_on), 32'h0000_0001);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_on(2, 1'b1, 300);
    chk("pulse", 32'(status_pulse), 32'h0000_0001);
    @(negedge ref_clk);
    chk("flt_off", 32'(charge_on), 32'h0000_0000);
    n = 1;
    while (status_pulse === 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("pulse_len", 32'(n), 32'h0000_0004);
    rdreg(ADDR_STATUS);
    chk("flt_code", 32'(rd[6:4]), 32'(FAULT_TIMER));
    wr(ADDR_CTRL, 32'h0000_0007);
    rdreg(ADDR_STATUS);
    chk("flt_kept", 32'(rd[6:4]), 32'(FAULT_TIMER));
    chk("flt_chg", 32'(charge_on), 32'h0000_0000);
    do_reset();
    rdreg(ADDR_STATUS);
    chk("flt_por", 32'(rd[6:4]), 32'(FAULT_NONE));
    $display("test fault done");
    end_sim();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
endmodule // tb_top
